// File: bench/amrf_ana_model.sv
`timescale 1ns/1ns
`default_nettype none
module amrf_ana_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic anaStart,
    input wire logic [10:0] rawValue,
    input wire logic [3:0] delay,
    output logic anaDone,
    output logic [10:0] anaResult
);
    logic [3:0] wait_r;
    logic busy_r;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            busy_r <= 1'h0;
            wait_r <= 4'h0;
            anaDone <= 1'h0;
            anaResult <= 11'h000;
        end else begin
            anaDone <= 1'h0;
            // Result bus only valid with done
            anaResult <= ~anaResult;
            if (anaStart) begin
                busy_r <= 1'h1;
                wait_r <= delay;
            end else if (busy_r && wait_r != 4'h0) begin
                wait_r <= wait_r - 4'h1;
            end else if (busy_r) begin
                busy_r <= 1'h0;
                anaDone <= 1'h1;
                anaResult <= rawValue;
            end
        end
    end
endmodule
`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb
    import amrf_pkg::*;
;
    logic clock, rst_n, psel, penable, pwrite, pready, pslverr, anaStart, anaDone, anaIntRefEn;
    logic anaDiff, anaBandgap, anaGround, anaOpen, convDoneFlag;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [10:0] anaResult, rawValue;
    logic [1:0] anaRefSel, anaNegSel;
    logic [2:0] anaPosSel;
    logic [3:0] delay;
    int miscompares = 0;
    int checkCount = 0;
    amrf_top amrf_top_inst (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .anaStart(anaStart), .anaDone(anaDone), .anaResult(anaResult), .anaRefSel(anaRefSel),
        .anaIntRefEn(anaIntRefEn), .anaPosSel(anaPosSel), .anaNegSel(anaNegSel), .anaDiff(anaDiff),
        .anaBandgap(anaBandgap), .anaGround(anaGround), .anaOpen(anaOpen), .convDoneFlag(convDoneFlag));
    amrf_ana_model amrf_ana_model_inst (.clock(clock), .rst_n(rst_n), .anaStart(anaStart),
        .rawValue(rawValue), .delay(delay), .anaDone(anaDone), .anaResult(anaResult));
    always #50 clock = ~clock;
    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", checkCount, miscompares);
        if (miscompares == 0 && checkCount > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checkCount++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] v, output logic [31:0] rd,
        output logic err);
        @(posedge clock);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= v;
        @(posedge clock);
        penable <= 1'h1;
        @(posedge clock);
        while (pready !== 1'h1) begin
            @(posedge clock);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wrReg(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] d;
        logic e;
        apb(1'h1, a, v, d, e);
    endtask
    task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic e;
        apb(1'h0, a, 32'h0, d, e);
        chk(what, exp, d);
    endtask
    task automatic ctrlChk(input string what, input logic [1:0] exp);
        logic [31:0] d;
        logic e;
        apb(1'h0, ADDR_CTRL, 32'h0, d, e);
        chk(what, {30'h0, exp}, {30'h0, d[CTRL_DONE_BIT], d[CTRL_START_BIT]});
    endtask
    task automatic startConv(input logic [10:0] raw);
        @(posedge clock);
        rawValue <= raw;
        wrReg(ADDR_CTRL, 32'h11);
    endtask
    task automatic waitDone;
        @(posedge clock);
        while (anaDone !== 1'h1) begin
            @(posedge clock);
        end
        @(posedge clock);
        @(negedge clock);
    endtask
    task automatic conv(input logic [10:0] raw);
        startConv(raw);
        waitDone;
    endtask
    function automatic logic [8:0] decExp(input logic [4:0] ch);
        if (ch <= CH_SINGLE_LAST) return {4'h0, ch[2:0], 2'h0};
        if (ch < CH_DIFF_FIRST) return 9'h020;
        if (ch <= CH_DIFF_LAST) return {4'h8, ch[2:0], (ch < CH_NEG2_FIRST) ? NEG_INPUT1 : NEG_INPUT2};
        return (ch == CH_BANDGAP) ? 9'h080 : 9'h040;
    endfunction
    task automatic t_reset;
        logic [31:0] d;
        logic e;
        rdChk("select reset", ADDR_SELECT, 32'h0);
        rdChk("low reset", ADDR_RES_LOW, 32'h0);
        rdChk("high reset", ADDR_RES_HIGH, 32'h0);
        ctrlChk("control reset", 2'h0);
        apb(1'h1, 8'h14, 32'hFF, d, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        rdChk("select kept", ADDR_SELECT, 32'h0);
    endtask
    task automatic t_decode;
        logic [4:0] chs [10] = '{5'h03, 5'h07, 5'h10, 5'h17, 5'h18, 5'h1D, 5'h1E, 5'h1F, 5'h08, 5'h0F};
        logic [7:0] v;
        logic [8:0] e;
        for (int i = 0; i < 10; i++) begin
            v = {i[1:0], i[0], chs[i]};
            e = decExp(chs[i]);
            wrReg(ADDR_SELECT, {24'h0, v});
            rdChk("select readback", ADDR_SELECT, {24'h0, v});
            chk("reference", {30'h0, v[7:6]}, {30'h0, anaRefSel});
            chk("internal ref", {31'h0, v[7:6] == REF_INTERNAL}, {31'h0, anaIntRefEn});
            chk("decode", {23'h0, e}, {23'h0, anaDiff, anaBandgap, anaGround, anaOpen,
                (e[7:5] == 3'h0) ? {anaPosSel, anaNegSel} : 5'h00});
        end
    endtask
    task automatic t_convert;
        wrReg(ADDR_SELECT, 32'h42);
        conv(11'h400);
        ctrlChk("done status", 2'h2);
        rdChk("se low", ADDR_RES_LOW, 32'hFF);
        rdChk("se high", ADDR_RES_HIGH, 32'h03);
        wrReg(ADDR_SELECT, 32'h62);
        rdChk("left low", ADDR_RES_LOW, 32'hC0);
        rdChk("left high", ADDR_RES_HIGH, 32'hFF);
        wrReg(ADDR_CTRL, 32'h10);
        @(negedge clock);
        chk("flag cleared", 32'h0, {31'h0, convDoneFlag});
        wrReg(ADDR_SELECT, 32'hFB);
        conv(11'h7A3);
        chk("flag set", 32'h1, {31'h0, convDoneFlag});
        rdChk("diff low", ADDR_RES_LOW, 32'hC0);
        rdChk("diff high", ADDR_RES_HIGH, 32'hE8);
        wrReg(ADDR_SELECT, 32'hDB);
        rdChk("diff right low", ADDR_RES_LOW, 32'hA3);
        rdChk("diff right high", ADDR_RES_HIGH, 32'h03);
        conv(11'h200);
        rdChk("diff sat low", ADDR_RES_LOW, 32'hFF);
        rdChk("diff sat high", ADDR_RES_HIGH, 32'h01);
    endtask
    task automatic t_defer;
        wrReg(ADDR_SELECT, 32'h01);
        delay <= 4'hF;
        startConv(11'h155);
        @(negedge clock);
        chk("start pulse", 32'h1, {31'h0, anaStart});
        @(negedge clock);
        chk("start ends", 32'h0, {31'h0, anaStart});
        ctrlChk("busy", 2'h1);
        wrReg(ADDR_SELECT, 32'hE5);
        repeat (2) @(negedge clock);
        chk("held channel", 32'h1, {29'h0, anaPosSel});
        chk("held reference", 32'h0, {30'h0, anaRefSel});
        rdChk("adjust at once", ADDR_RES_HIGH, 32'h7F);
        waitDone;
        chk("new channel", 32'h5, {29'h0, anaPosSel});
        chk("new reference", 32'h3, {30'h0, anaRefSel});
        rdChk("deferred high", ADDR_RES_HIGH, 32'h55);
    endtask
    task automatic t_lock;
        wrReg(ADDR_SELECT, 32'h05);
        rdChk("low locks", ADDR_RES_LOW, 32'h55);
        conv(11'h0AA);
        chk("no flag locked", 32'h0, {31'h0, convDoneFlag});
        rdChk("high held", ADDR_RES_HIGH, 32'h01);
        conv(11'h0AA);
        rdChk("new low", ADDR_RES_LOW, 32'hAA);
        rdChk("new high", ADDR_RES_HIGH, 32'h00);
    endtask
    task automatic t_midReset;
        wrReg(ADDR_SELECT, 32'hE5);
        @(posedge clock);
        rst_n <= 1'h0;
        repeat (2) @(posedge clock);
        rst_n <= 1'h1;
        rdChk("select after reset", ADDR_SELECT, 32'h0);
        chk("reference after reset", 32'h0, {30'h0, anaRefSel});
        ctrlChk("control after reset", 2'h0);
        rdChk("high after reset", ADDR_RES_HIGH, 32'h0);
    endtask
    initial begin
        clock = 1'h0;
        rst_n = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        rawValue = 11'h000;
        delay = 4'h2;
        repeat (2) @(posedge clock);
        rst_n <= 1'h1;
        t_reset;
        t_decode;
        t_convert;
        t_defer;
        t_lock;
        t_midReset;
        wrap_up;
    end
    initial begin
        repeat (5000) @(posedge clock);
        miscompares++;
        wrap_up;
    end
endmodule
`default_nettype wire

// File: rtl/amrf_pkg.sv
package amrf_pkg;
    // ----------------------------------------
    // Register byte addresses
    // ----------------------------------------
    localparam logic [7:0] ADDR_SELECT = 8'h00;
    localparam logic [7:0] ADDR_RES_LOW = 8'h04;
    localparam logic [7:0] ADDR_RES_HIGH = 8'h08;
    localparam logic [7:0] ADDR_CTRL = 8'h0C;

    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int REF_LSB = 6;
    localparam int LADJ_BIT = 5;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_DONE_BIT = 4;
    localparam logic [7:0] SELECT_RST = 8'h00;
    localparam logic [9:0] RESULT_RST = 10'h000;

    // ----------------------------------------
    // Reference and channel codes
    // ----------------------------------------
    localparam logic [1:0] REF_PIN = 2'h0;
    localparam logic [1:0] REF_SUPPLY = 2'h1;
    localparam logic [1:0] REF_RESERVED = 2'h2;
    localparam logic [1:0] REF_INTERNAL = 2'h3;
    localparam logic [4:0] CH_SINGLE_LAST = 5'h07;
    localparam logic [4:0] CH_DIFF_FIRST = 5'h10;
    localparam logic [4:0] CH_NEG2_FIRST = 5'h18;
    localparam logic [4:0] CH_DIFF_LAST = 5'h1D;
    localparam logic [4:0] CH_BANDGAP = 5'h1E;
    localparam logic [4:0] CH_GROUND = 5'h1F;
    localparam logic [1:0] NEG_INPUT1 = 2'h1;
    localparam logic [1:0] NEG_INPUT2 = 2'h2;

    // ----------------------------------------
    // Result codes
    // ----------------------------------------
    localparam logic [9:0] CODE_SE_MAX = 10'h3FF;
    localparam logic [9:0] CODE_DIFF_MAX = 10'h1FF;
    localparam logic [9:0] CODE_DIFF_MIN = 10'h200;

    typedef enum logic {AMRF_IDLE, AMRF_BUSY} amrf_state_e;

    // Byte of the result pair as software sees it
    function automatic logic [7:0] amrf_present(input logic [9:0] res, input logic ladj, input logic high);
        logic [7:0] b;
        if (ladj) begin
            b = high ? res[9:2] : {res[1:0], 6'h00};
        end else begin
            b = high ? {6'h00, res[9:8]} : res[7:0];
        end
        return b;
    endfunction
endpackage

// File: rtl/amrf_sel_if.sv
`timescale 1ns/1ns
`default_nettype none
interface amrf_sel_if;
    logic [4:0] channel;
    logic [10:0] rawCode;
    logic [9:0] code;
    logic diff;
    logic [2:0] posSel;
    logic [1:0] negSel;
    logic bandgap;
    logic ground;
    logic open;
    modport ctrl (output channel, output rawCode, input code, input diff, input posSel, input negSel,
        input bandgap, input ground, input open);
    modport dec (input channel, input rawCode, output code, output diff, output posSel, output negSel,
        output bandgap, output ground, output open);
endinterface
`default_nettype wire

// File: rtl/amrf_select.sv
`timescale 1ns/1ns
`default_nettype none
module amrf_select
    import amrf_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    amrf_sel_if.dec sel
);
    // ----------------------------------------
    // Channel decode
    // ----------------------------------------
    always_comb begin
        sel.diff = 1'b0;
        sel.posSel = sel.channel[2:0];
        sel.negSel = 2'h0;
        sel.bandgap = 1'b0;
        sel.ground = 1'b0;
        sel.open = 1'b0;
        if (sel.channel <= CH_SINGLE_LAST) begin
            sel.posSel = sel.channel[2:0];
        end else if (sel.channel < CH_DIFF_FIRST) begin
            sel.open = 1'b1;
        end else if (sel.channel <= CH_DIFF_LAST) begin
            sel.diff = 1'b1;
            sel.negSel = (sel.channel < CH_NEG2_FIRST) ? NEG_INPUT1 : NEG_INPUT2;
        end else if (sel.channel == CH_BANDGAP) begin
            sel.bandgap = 1'b1;
        end else begin
            sel.ground = 1'b1;
        end
    end

    // ----------------------------------------
    // Result encoding with saturation
    // ----------------------------------------
    always_comb begin
        if (sel.diff) begin
            if (!sel.rawCode[10] && sel.rawCode[9]) begin
                sel.code = CODE_DIFF_MAX;
            end else if (sel.rawCode[10] && !sel.rawCode[9]) begin
                sel.code = CODE_DIFF_MIN;
            end else begin
                sel.code = sel.rawCode[9:0];
            end
        end else begin
            sel.code = sel.rawCode[10] ? CODE_SE_MAX : sel.rawCode[9:0];
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    single_code_a: assert property (!sel.diff |-> sel.code == (sel.rawCode[10] ? 10'h3FF : sel.rawCode[9:0]))
        else $error("single-ended code wrong");
    diff_sat_a: assert property (sel.diff && sel.rawCode == 11'h200 |-> sel.code == 10'h1FF)
        else $error("differential full scale not saturated");
    diff_pair_a: assert property (sel.channel[4:3] == 2'h2 |-> sel.diff && sel.negSel == 2'h1 &&
        sel.posSel == sel.channel[2:0])
        else $error("differential pair against input 1 wrong");
    fixed_inputs_a: assert property ((sel.channel == 5'h1E |-> sel.bandgap && !sel.diff) and
        (sel.channel == 5'h1F |-> sel.ground && !sel.bandgap))
        else $error("bandgap or ground decode wrong");
    open_code_a: assert property (sel.channel[4:3] == 2'h1 |-> sel.open && !sel.diff)
        else $error("unused channel code drives an input");
endmodule
`default_nettype wire

// File: rtl/amrf_top.sv
`timescale 1ns/1ns
`default_nettype none
// Contract
// - A conversion that finishes while no low byte read holds the result is shown in the result low and high byte registers once the done flag is high.
// - Single-ended inputs give an unsigned ten-bit code, zero at ground and 0x3FF at one step below the reference.
// - Differential pairs give a ten-bit two's complement code from 0x200 to 0x1FF, saturating at 0x1FF.
// - The input select register holds reference in bits 7:6, left adjust in bit 5, channel in bits 4:0, reset zero.
// - Reference code 0 is the reference pin with internal reference off, 1 the supply, 2 reserved, 3 internal.
// - Reference and channel writes during a conversion take effect only after that conversion completes.
// - Left adjust chooses left or right alignment of the result pair and acts at once, even mid-conversion.
// - Channel codes 0 to 7 pick single inputs 0 to 7, code 0x1E the bandgap and 0x1F ground.
// - Codes 0x10 to 0x17 pair inputs 0 to 7 against input 1, codes 0x18 to 0x1D inputs 0 to 5 against input 2.
// - After the low byte is read the result registers hold until the high byte is read.
// - The done flag sets when a conversion completes and the result registers are updated.
module amrf_top
    import amrf_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic anaStart,
    input wire logic anaDone,
    input wire logic [10:0] anaResult,
    output logic [1:0] anaRefSel,
    output logic anaIntRefEn,
    output logic [2:0] anaPosSel,
    output logic [1:0] anaNegSel,
    output logic anaDiff,
    output logic anaBandgap,
    output logic anaGround,
    output logic anaOpen,
    output logic convDoneFlag
);
    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    logic access;
    logic busWr;
    logic busRd;
    logic mapped;
    logic [7:0] inputSel_r;
    logic [7:0] liveSel_r;
    logic [9:0] result_r;
    logic doneFlag_r;
    logic lowRead_r;
    logic anaStart_r;
    amrf_state_e state_r;
    logic finish;
    logic startReq;
    logic resultLocked;
    amrf_sel_if sel ();

    assign access = psel && penable;
    assign busWr = access && pwrite;
    assign busRd = access && !pwrite;
    assign mapped = (paddr == ADDR_SELECT) || (paddr == ADDR_RES_LOW) || (paddr == ADDR_RES_HIGH) ||
        (paddr == ADDR_CTRL);
    assign pready = 1'b1;
    assign pslverr = access && !mapped;
    assign finish = (state_r == AMRF_BUSY) && anaDone;
    assign startReq = busWr && (paddr == ADDR_CTRL) && pwdata[CTRL_START_BIT] && (state_r == AMRF_IDLE);
    // Low byte read in this cycle locks too, so the pair never tears
    assign resultLocked = lowRead_r || (busRd && (paddr == ADDR_RES_LOW));

    always_comb begin
        prdata = 32'h0000_0000;
        if (busRd) begin
            case (paddr)
                ADDR_SELECT: prdata[7:0] = inputSel_r;
                ADDR_RES_LOW: prdata[7:0] = amrf_present(result_r, inputSel_r[LADJ_BIT], 1'b0);
                ADDR_RES_HIGH: prdata[7:0] = amrf_present(result_r, inputSel_r[LADJ_BIT], 1'b1);
                ADDR_CTRL: begin
                    prdata[CTRL_START_BIT] = (state_r == AMRF_BUSY);
                    prdata[CTRL_DONE_BIT] = doneFlag_r;
                end
                default: prdata = 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------
    // Input select register and live copy
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            inputSel_r <= SELECT_RST;
        end else if (busWr && paddr == ADDR_SELECT) begin
            inputSel_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            liveSel_r <= SELECT_RST;
        end else if (state_r == AMRF_IDLE) begin
            liveSel_r <= inputSel_r;
        end
    end

    // ----------------------------------------
    // Conversion sequencing
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_r <= AMRF_IDLE;
        end else begin
            case (state_r)
                AMRF_IDLE: if (startReq) begin
                    state_r <= AMRF_BUSY;
                end
                AMRF_BUSY: if (anaDone) begin
                    state_r <= AMRF_IDLE;
                end
                default: state_r <= AMRF_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            anaStart_r <= 1'b0;
        end else begin
            anaStart_r <= startReq;
        end
    end

    // ----------------------------------------
    // Result registers, read lock and done flag
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            lowRead_r <= 1'b0;
        end else if (busRd && paddr == ADDR_RES_LOW) begin
            lowRead_r <= 1'b1;
        end else if (busRd && paddr == ADDR_RES_HIGH) begin
            lowRead_r <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            result_r <= RESULT_RST;
        end else if (finish && !resultLocked) begin
            result_r <= sel.code;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            doneFlag_r <= 1'b0;
        end else if (finish && !resultLocked) begin
            doneFlag_r <= 1'b1;
        end else if (busWr && paddr == ADDR_CTRL && pwdata[CTRL_DONE_BIT]) begin
            doneFlag_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // Analog side
    // ----------------------------------------
    assign sel.channel = liveSel_r[4:0];
    assign sel.rawCode = anaResult;
    assign anaStart = anaStart_r;
    assign anaRefSel = liveSel_r[7:REF_LSB];
    assign anaIntRefEn = (liveSel_r[7:REF_LSB] == REF_INTERNAL);
    assign anaPosSel = sel.posSel;
    assign anaNegSel = sel.negSel;
    assign anaDiff = sel.diff;
    assign anaBandgap = sel.bandgap;
    assign anaGround = sel.ground;
    assign anaOpen = sel.open;
    assign convDoneFlag = doneFlag_r;

    amrf_select u_select (
        .clock(clock),
        .rst_n(rst_n),
        .sel(sel.dec)
    );

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence convDoneSeq;
        state_r == AMRF_BUSY && anaDone && !resultLocked;
    endsequence
    sequence lowThenHeld;
        busRd && paddr == ADDR_RES_LOW ##1 lowRead_r;
    endsequence

    done_update_a: assert property (convDoneSeq |=> doneFlag_r && result_r == $past(sel.code))
        else $error("done flag or result not updated at completion");
    sel_locked_a: assert property (state_r == AMRF_BUSY && $past(state_r == AMRF_BUSY) |-> $stable(liveSel_r))
        else $error("selection changed during conversion");
    sel_apply_a: assert property (state_r == AMRF_IDLE |=> liveSel_r == $past(inputSel_r))
        else $error("selection not applied while idle");
    result_lock_a: assert property (lowThenHeld |-> $stable(result_r) && $stable(doneFlag_r))
        else $error("result changed while low byte read");
    lock_hold_a: assert property (lowRead_r && !(busRd && paddr == ADDR_RES_HIGH) |=> $stable(result_r))
        else $error("result updated before high byte read");
    left_adjust_a: assert property (busRd && paddr == ADDR_RES_HIGH && inputSel_r[5] |->
        prdata[7:0] == result_r[9:2])
        else $error("left adjusted high byte wrong");
    right_adjust_a: assert property (busRd && paddr == ADDR_RES_LOW && !inputSel_r[5] |->
        prdata[7:0] == result_r[7:0])
        else $error("right adjusted low byte wrong");
    select_write_a: assert property (busWr && paddr == ADDR_SELECT |=> inputSel_r == $past(pwdata[7:0]))
        else $error("select register write lost");
    int_ref_a: assert property (anaIntRefEn |-> liveSel_r[7:6] == 2'h3 && anaRefSel == 2'h3)
        else $error("internal reference enabled for wrong code");
endmodule
`default_nettype wire
